// >>> hw/lch_comparator.sv
// four-limit decision comparator with hysteresis, patterns and gating
`include "lch_defines.svh"

module lch_comparator #(
  parameter int unsigned STAB_WINDOW_CYC = `LCH_STAB_WINDOW_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // measurement from the front end
  input wire logic signed [19:0] reading,
  input wire logic hold_active,
  // limit editing
  input wire logic [1:0] edit_slot,
  input wire logic [19:0] edit_magnitude,
  input wire logic edit_load,
  input wire logic sign_key,
  input wire logic edit_commit,
  // configuration
  input wire logic outer_limit_enable,
  input wire logic [19:0] hysteresis_setting,
  input wire logic [2:0] comparison_gating_mode,
  input wire logic output_pattern_select,
  input wire logic block_setting_enable,
  input wire logic verdict_gate,
  input wire logic [19:0] near_zero_range,
  input wire logic [19:0] motion_bandwidth,
  input wire logic [15:0] motion_detect_ticks,
  input wire logic [3:0] hold_select,
  input wire logic adjust_lock,
  input wire logic parameter_lock,
  // decision outputs
  output logic extreme_over_out,
  output logic over_out,
  output logic pass_out,
  output logic under_out,
  output logic extreme_under_out,
  // status
  output logic ordering_error,
  output logic [7:0] ordering_error_code,
  output logic signed [19:0] edit_value,
  output logic compare_active,
  output logic stable,
  output logic near_zero,
  // indicators
  output lch_pkg::lch_led_t upper_led,
  output lch_pkg::lch_led_t pass_led,
  output lch_pkg::lch_led_t lower_led,
  output lch_pkg::lch_led_t verdict_led,
  output lch_pkg::lch_led_t hold_led [4],
  output lch_pkg::lch_led_t adjust_lock_led,
  output lch_pkg::lch_led_t parameter_lock_led
);

  // ==========================================================
  // helper functions
  // ==========================================================

  // gating decision from mode and measurement flags
  function automatic logic gate_allows(
    input logic [2:0] mode,
    input logic stb,
    input logic nz,
    input logic hld
  );
    logic ok;
    ok = 1'b0;
    unique case (mode)
      lch_pkg::LCH_GATE_ALWAYS: ok = 1'b1;
      lch_pkg::LCH_GATE_STABLE: ok = stb;
      lch_pkg::LCH_GATE_COMPARE_EXCEPT_ZERO: ok = !nz;
      lch_pkg::LCH_GATE_COMPARE_STABLE_NONZERO: ok = stb && !nz;
      lch_pkg::LCH_GATE_COMPARE_IN_HOLD: ok = hld;
      lch_pkg::LCH_GATE_OFF: ok = 1'b0;
      default: ok = 1'b0; // codes 6 and 7 are illegal: treat as off
    endcase
    return ok;
  endfunction

  // signed magnitude from slot staging
  function automatic logic signed [19:0] signed_of(
    input logic neg,
    input logic [19:0] mag
  );
    logic signed [19:0] v;
    v = neg ? 20'(-mag) : mag;
    return v;
  endfunction

  // ==========================================================
  // limit staging and commit
  // ==========================================================

  logic [19:0] stage_mag_q [4];
  logic stage_neg_q [4];
  logic signed [19:0] stage_val [4];
  logic signed [19:0] lim_xo_q;
  logic signed [19:0] lim_o_q;
  logic signed [19:0] lim_u_q;
  logic signed [19:0] lim_xu_q;
  logic order_ok;
  logic err_q;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_stage
      // one edit buffer per limit; sign toggles independent of digits
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          stage_mag_q[gi] <= 20'h0_0000;
          stage_neg_q[gi] <= 1'b0;
        end
        else if (edit_slot == 2'(gi))
        begin
          if (edit_load)
            stage_mag_q[gi] <= edit_magnitude;
          if (sign_key)
            stage_neg_q[gi] <= !stage_neg_q[gi];
        end
      end
      assign stage_val[gi] = signed_of(stage_neg_q[gi], stage_mag_q[gi]);
    end
  endgenerate

  // the whole set must be strictly ordered before it is accepted
  assign order_ok =
    (stage_val[`LCH_SLOT_EXT_UNDER] < stage_val[`LCH_SLOT_UNDER]) &&
    (stage_val[`LCH_SLOT_UNDER] < stage_val[`LCH_SLOT_OVER]) &&
    (stage_val[`LCH_SLOT_OVER] < stage_val[`LCH_SLOT_EXT_OVER]);

  // store the set or refuse it; old limits survive a refusal
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lim_xo_q <= `LCH_RST_EXT_OVER;
      lim_o_q <= `LCH_RST_OVER;
      lim_u_q <= `LCH_RST_UNDER;
      lim_xu_q <= `LCH_RST_EXT_UNDER;
      err_q <= 1'b0;
    end
    else if (edit_commit)
    begin
      if (order_ok)
      begin
        lim_xo_q <= stage_val[`LCH_SLOT_EXT_OVER];
        lim_o_q <= stage_val[`LCH_SLOT_OVER];
        lim_u_q <= stage_val[`LCH_SLOT_UNDER];
        lim_xu_q <= stage_val[`LCH_SLOT_EXT_UNDER];
        err_q <= 1'b0;
      end
      else
        err_q <= 1'b1;
    end
  end

  assign ordering_error = err_q;
  assign ordering_error_code = err_q ? `LCH_ERR_ORDERING : 8'h00;
  assign edit_value = stage_val[edit_slot];

  // ==========================================================
  // motion and near-zero detection
  // ==========================================================

  lch_meas_if meas_if ();

  assign meas_if.reading = reading;
  assign meas_if.bandwidth = motion_bandwidth;
  assign meas_if.detect_ticks = motion_detect_ticks;
  assign meas_if.near_range = near_zero_range;

  lch_motion #(
    .WINDOW_CYC(STAB_WINDOW_CYC)
  ) u_motion (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .meas(meas_if.det)
  );

  assign stable = meas_if.stable;
  assign near_zero = meas_if.near_zero;

  // ==========================================================
  // threshold comparison with hysteresis
  // ==========================================================

  logic cmp_en;
  logic signed [21:0] rd_w;
  logic signed [21:0] hys_w;
  logic xo_q;
  logic o_q;
  logic u_q;
  logic xu_q;
  logic pass_q;
  logic xo_at_q;
  logic xu_at_q;

  assign cmp_en = gate_allows(comparison_gating_mode, meas_if.stable,
                              meas_if.near_zero, hold_active);
  assign compare_active = cmp_en;
  assign rd_w = 22'(reading);
  // one shared amount; zero makes on and off points coincide
  assign hys_w = 22'(signed'({1'b0, hysteresis_setting}));

  // upper limits: on above, released only once back at or below limit minus
  // hysteresis, so the band only acts on a falling reading
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xo_q <= 1'b0;
      o_q <= 1'b0;
    end
    else if (!cmp_en)
    begin
      xo_q <= 1'b0;
      o_q <= 1'b0;
    end
    else
    begin
      if (rd_w > 22'(lim_xo_q))
        xo_q <= 1'b1;
      else if (rd_w <= 22'(lim_xo_q) - hys_w)
        xo_q <= 1'b0;
      if (rd_w > 22'(lim_o_q))
        o_q <= 1'b1;
      else if (rd_w <= 22'(lim_o_q) - hys_w)
        o_q <= 1'b0;
    end
  end

  // lower limits: mirror image, band acts on a rising reading
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      u_q <= 1'b0;
      xu_q <= 1'b0;
    end
    else if (!cmp_en)
    begin
      u_q <= 1'b0;
      xu_q <= 1'b0;
    end
    else
    begin
      if (rd_w < 22'(lim_u_q))
        u_q <= 1'b1;
      else if (rd_w >= 22'(lim_u_q) + hys_w)
        u_q <= 1'b0;
      if (rd_w < 22'(lim_xu_q))
        xu_q <= 1'b1;
      else if (rd_w >= 22'(lim_xu_q) + hys_w)
        xu_q <= 1'b0;
    end
  end

  // pass band is inclusive at both ends and has no hysteresis
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pass_q <= 1'b0;
    else
      pass_q <= cmp_en && (reading >= lim_u_q) &&
                (reading <= lim_o_q);
  end

  // a reading sitting exactly on an outer limit is in neither area band;
  // the outer state alone would leave the inner output on at that point
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xo_at_q <= 1'b0;
      xu_at_q <= 1'b0;
    end
    else
    begin
      xo_at_q <= cmp_en && (reading == lim_xo_q);
      xu_at_q <= cmp_en && (reading == lim_xu_q);
    end
  end

  // ==========================================================
  // output pattern
  // ==========================================================

  logic area;

  assign area = (output_pattern_select == lch_pkg::LCH_PAT_AREA);

  // the area pattern masks the inner output while the outer one is on;
  // with outer limits off the inner output has no upper bound to respect
  always_comb
  begin
    extreme_over_out = outer_limit_enable && xo_q;
    extreme_under_out = outer_limit_enable && xu_q;
    if (area && outer_limit_enable)
    begin
      over_out = o_q && !xo_q && !xo_at_q;
      under_out = u_q && !xu_q && !xu_at_q;
    end
    else
    begin
      over_out = o_q;
      under_out = u_q;
    end
    pass_out = pass_q;
  end

  // ==========================================================
  // indicators
  // ==========================================================

  // upper and lower two-colour lamps; red wins over orange
  always_comb
  begin
    upper_led = lch_pkg::LCH_LED_OFF;
    lower_led = lch_pkg::LCH_LED_OFF;
    if (outer_limit_enable)
    begin
      if (xo_q)
        upper_led = lch_pkg::LCH_LED_RED;
      else if (o_q)
        upper_led = lch_pkg::LCH_LED_ORANGE;
      if (xu_q)
        lower_led = lch_pkg::LCH_LED_RED;
      else if (u_q)
        lower_led = lch_pkg::LCH_LED_ORANGE;
    end
    else
    begin
      if (o_q)
        upper_led = lch_pkg::LCH_LED_RED;
      if (u_q)
        lower_led = lch_pkg::LCH_LED_RED;
    end
  end

  assign pass_led = pass_q ? lch_pkg::LCH_LED_GREEN
                           : lch_pkg::LCH_LED_OFF;

  // without block setting there is no gate to follow, so it stays lit
  assign verdict_led = (!block_setting_enable || verdict_gate)
                       ? lch_pkg::LCH_LED_GREEN
                       : lch_pkg::LCH_LED_OFF;

  // hold lamps: index 0 peak, 1 bottom, 2 peak-to-peak, 3 sample;
  // sample hold has no block variant and never shows orange
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_hold_led
      always_comb
      begin
        if (!hold_select[gi])
          hold_led[gi] = lch_pkg::LCH_LED_OFF;
        else if (!hold_active)
          hold_led[gi] = lch_pkg::LCH_LED_GREEN;
        else if (block_setting_enable && (gi != 3))
          hold_led[gi] = lch_pkg::LCH_LED_ORANGE;
        else
          hold_led[gi] = lch_pkg::LCH_LED_RED;
      end
    end
  endgenerate

  // lock lamps are independent of each other
  assign adjust_lock_led = adjust_lock ? lch_pkg::LCH_LED_ORANGE
                                       : lch_pkg::LCH_LED_OFF;
  assign parameter_lock_led = parameter_lock ? lch_pkg::LCH_LED_ORANGE
                                             : lch_pkg::LCH_LED_OFF;

endmodule

// >>> hw/lch_defines.svh
// constants of the limit comparator: timing, reset values and codes
`ifndef LCH_DEFINES_SVH
`define LCH_DEFINES_SVH

// reading and limit width, signed two's complement
`define LCH_RD_W 20
// clock rate in MHz and the reference interval of the motion check
`define LCH_CLK_MHZ 100
`define LCH_STAB_WINDOW_MS 100
`define LCH_STAB_WINDOW_CYC (`LCH_STAB_WINDOW_MS * 1000 * `LCH_CLK_MHZ)
// code reported when a limit set is out of order
`define LCH_ERR_ORDERING 8'h08
// limit values after reset, already in legal order
`define LCH_RST_EXT_OVER 20'h0_0014
`define LCH_RST_OVER 20'h0_000A
`define LCH_RST_UNDER 20'hF_FFF6
`define LCH_RST_EXT_UNDER 20'hF_FFEC
// limit edit slots
`define LCH_SLOT_OVER 2'h0
`define LCH_SLOT_UNDER 2'h1
`define LCH_SLOT_EXT_OVER 2'h2
`define LCH_SLOT_EXT_UNDER 2'h3

`endif

// >>> hw/lch_meas_if.sv
// measurement flags passed from the motion detector to the comparator
interface lch_meas_if;
  logic signed [19:0] reading;
  logic [19:0] bandwidth;
  logic [15:0] detect_ticks;
  logic [19:0] near_range;
  logic stable;
  logic near_zero;

  modport det (
    input reading, bandwidth, detect_ticks, near_range,
    output stable, near_zero
  );
  modport cmp (
    output reading, bandwidth, detect_ticks, near_range,
    input stable, near_zero
  );
endinterface

// >>> hw/lch_motion.sv
// motion (stability) and near-zero detector for the limit comparator
`include "lch_defines.svh"

module lch_motion #(
  parameter int unsigned WINDOW_CYC = `LCH_STAB_WINDOW_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // measurement flags
  lch_meas_if.det meas
);

  logic [31:0] win_cnt_q;
  logic tick;
  logic signed [19:0] ref_q;
  logic signed [20:0] diff;
  logic [20:0] diff_abs;
  logic [20:0] rd_abs;
  logic [15:0] run_q;
  logic stable_q;
  logic near_q;

  // reference interval timer
  assign tick = (win_cnt_q == WINDOW_CYC - 1);
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      win_cnt_q <= 32'h0000_0000;
    else if (tick)
      win_cnt_q <= 32'h0000_0000;
    else
      win_cnt_q <= win_cnt_q + 32'h0000_0001;
  end

  // distance from the reading one interval earlier
  assign diff = 21'(meas.reading) - 21'(ref_q);
  assign diff_abs = diff[20] ? 21'(-diff) : 21'(diff);

  // count intervals spent in band; any excursion restarts the run
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_q <= 20'sh0_0000;
      run_q <= 16'h0000;
      stable_q <= 1'b0;
    end
    else if (tick)
    begin
      ref_q <= meas.reading;
      if (diff_abs <= {1'b0, meas.bandwidth})
      begin
        if (run_q != 16'hFFFF)
          run_q <= run_q + 16'h0001;
        stable_q <= (run_q >= meas.detect_ticks);
      end
      else
      begin
        run_q <= 16'h0000;
        stable_q <= 1'b0;
      end
    end
  end

  // near-zero window, symmetric around zero
  assign rd_abs = meas.reading[19] ? 21'(-21'(meas.reading))
                                   : 21'(meas.reading);
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      near_q <= 1'b0;
    else
      near_q <= (rd_abs <= {1'b0, meas.near_range});
  end

  assign meas.stable = stable_q;
  assign meas.near_zero = near_q;

endmodule

// >>> hw/lch_pkg.sv
// types shared by the limit comparator modules
package lch_pkg;

  // two-colour indicator drive
  typedef enum logic [1:0] {
    LCH_LED_OFF = 2'h0,
    LCH_LED_GREEN = 2'h1,
    LCH_LED_ORANGE = 2'h2,
    LCH_LED_RED = 2'h3
  } lch_led_t;

  // comparison gating mode codes
  typedef enum logic [2:0] {
    LCH_GATE_ALWAYS = 3'h0,
    LCH_GATE_STABLE = 3'h1,
    LCH_GATE_COMPARE_EXCEPT_ZERO = 3'h2,
    LCH_GATE_COMPARE_STABLE_NONZERO = 3'h3,
    LCH_GATE_COMPARE_IN_HOLD = 3'h4,
    LCH_GATE_OFF = 3'h5
  } lch_gate_t;

  // output pattern select codes
  typedef enum logic {
    LCH_PAT_STANDARD = 1'b0,
    LCH_PAT_AREA = 1'b1
  } lch_pattern_t;

endpackage

// >>> testbench/lch_comparator_properties.sv
// concurrent checks on the ports of the limit comparator
module lch_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // controls
  input wire logic hold_active,
  input wire logic [2:0] comparison_gating_mode,
  input wire logic outer_limit_enable,
  input wire logic block_setting_enable,
  input wire logic adjust_lock,
  input wire logic parameter_lock,
  // decisions and status
  input wire logic extreme_over_out,
  input wire logic over_out,
  input wire logic pass_out,
  input wire logic under_out,
  input wire logic extreme_under_out,
  input wire logic ordering_error,
  input wire logic [7:0] ordering_error_code,
  input wire logic compare_active,
  input wire logic stable,
  input wire logic near_zero,
  // indicators
  input wire lch_pkg::lch_led_t upper_led,
  input wire lch_pkg::lch_led_t verdict_led,
  input wire lch_pkg::lch_led_t adjust_lock_led,
  input wire lch_pkg::lch_led_t parameter_lock_led
);
  // ==========================================================
  // helpers
  logic any_dec;
  // any decision or pass output that gating must silence
  assign any_dec = extreme_over_out | over_out | under_out |
    extreme_under_out | pass_out;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // assertions
  a_outer_off_quiet: assert property (
    !outer_limit_enable |-> !extreme_over_out && !extreme_under_out)
    else $error("extreme output active with outer limits off");
  a_error_code_value: assert property (
    ordering_error_code == (ordering_error ? 8'h08 : 8'h00))
    else $error("ordering error code does not match error flag");
  a_gate_clears_all: assert property (
    !compare_active |=> !any_dec)
    else $error("decision output survived suppressed comparison");
  a_rise_needs_compare: assert property (
    $rose(over_out) |-> $past(compare_active))
    else $error("over output rose without comparison");
  a_mode_always_on: assert property (
    comparison_gating_mode == 3'h0 |-> compare_active)
    else $error("continuous mode not comparing");
  a_mode_off_idle: assert property (
    comparison_gating_mode >= 3'h5 |-> !compare_active)
    else $error("off mode still comparing");
  a_mode_near_zero: assert property (
    comparison_gating_mode == 3'h2 |-> compare_active == !near_zero)
    else $error("near zero gating wrong");
  a_mode_stable_gate: assert property (
    comparison_gating_mode == 3'h1 |-> compare_active == stable)
    else $error("stable gating wrong");
  a_mode_hold_gate: assert property (
    comparison_gating_mode == 3'h4 |-> compare_active == hold_active)
    else $error("hold gating wrong");
  a_extreme_shows_red: assert property (
    outer_limit_enable && extreme_over_out |->
      upper_led == lch_pkg::LCH_LED_RED)
    else $error("upper indicator not red above extreme");
  a_verdict_always_lit: assert property (
    !block_setting_enable |-> verdict_led == lch_pkg::LCH_LED_GREEN)
    else $error("verdict indicator dark without block setting");
  a_lock_leds_orange: assert property (
    adjust_lock_led == (adjust_lock ? 2'h2 : 2'h0) &&
    parameter_lock_led == (parameter_lock ? 2'h2 : 2'h0))
    else $error("lock indicator wrong");
endmodule

bind lch_comparator lch_properties lch_properties_i (.clk_sys, .rst_n,
  .hold_active, .comparison_gating_mode, .outer_limit_enable,
  .block_setting_enable, .adjust_lock, .parameter_lock, .extreme_over_out,
  .over_out, .pass_out, .under_out, .extreme_under_out, .ordering_error,
  .ordering_error_code, .compare_active, .stable, .near_zero, .upper_led,
  .verdict_led, .adjust_lock_led, .parameter_lock_led);

// >>> testbench/lch_comparator_tb.sv
// self-checking bench for the limit comparator
`include "lch_defines.svh"
module lch_comparator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic signed [19:0] reading, target, edit_value;
  logic hold_active, hold_req, edit_load, sign_key, edit_commit;
  logic outer_limit_enable, output_pattern_select, block_setting_enable;
  logic verdict_gate, adjust_lock, parameter_lock, stable, near_zero;
  logic [1:0] edit_slot;
  logic [19:0] edit_magnitude, hysteresis_setting, near_zero_range;
  logic [19:0] motion_bandwidth;
  logic [15:0] motion_detect_ticks;
  logic [2:0] comparison_gating_mode;
  logic [3:0] hold_select;
  logic extreme_over_out, over_out, pass_out, under_out, extreme_under_out;
  logic ordering_error, compare_active;
  logic [7:0] ordering_error_code;
  lch_pkg::lch_led_t upper_led, pass_led, lower_led, verdict_led;
  lch_pkg::lch_led_t adjust_lock_led, parameter_lock_led;
  lch_pkg::lch_led_t hold_led [4];
  localparam logic [1:0] led_green = lch_pkg::LCH_LED_GREEN;
  localparam logic [1:0] led_orange = lch_pkg::LCH_LED_ORANGE;
  localparam logic [1:0] led_red = lch_pkg::LCH_LED_RED;
  int n_mismatch = 0;
  int samples_checked = 0;
  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;
  // ==========================================================
  // instances
  lch_front_end #(.LAG(2)) lch_front_end_i (.clk_sys, .rst_n, .target,
    .hold_req, .reading, .hold_active);
  // short motion window keeps the stability checks quick
  lch_comparator #(.STAB_WINDOW_CYC(8)) lch_comparator_i (.clk_sys, .rst_n,
    .reading, .hold_active, .edit_slot, .edit_magnitude, .edit_load,
    .sign_key, .edit_commit, .outer_limit_enable, .hysteresis_setting,
    .comparison_gating_mode, .output_pattern_select, .block_setting_enable,
    .verdict_gate, .near_zero_range, .motion_bandwidth, .motion_detect_ticks,
    .hold_select, .adjust_lock, .parameter_lock, .extreme_over_out,
    .over_out, .pass_out, .under_out, .extreme_under_out, .ordering_error,
    .ordering_error_code, .edit_value, .compare_active, .stable, .near_zero,
    .upper_led, .pass_led, .lower_led, .verdict_led, .hold_led,
    .adjust_lock_led, .parameter_lock_led);
  // ==========================================================
  // shared tasks
  task automatic chk(input string what, input logic [19:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // move the reading; the front end needs a few cycles to settle
  task automatic put(input int v);
    target = 20'(v);
    step(6);
  endtask
  task automatic set_limit(input logic [1:0] s, input int v);
    edit_slot = s;
    edit_magnitude = 20'(v < 0 ? -v : v);
    edit_load = 1'b1;
    step(1);
    edit_load = 1'b0;
    step(1);
    if (edit_value[19] !== (v < 0))
    begin
      sign_key = 1'b1;
      step(1);
      sign_key = 1'b0;
      step(1);
    end
    chk("edit_value", edit_value, 20'(v));
  endtask
  task automatic limits(input int xo, o, u, xu);
    set_limit(2'h2, xo);
    set_limit(2'h0, o);
    set_limit(2'h1, u);
    set_limit(2'h3, xu);
    edit_commit = 1'b1;
    step(1);
    edit_commit = 1'b0;
    step(2);
  endtask
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_ordering();
    limits(200, 100, -100, -200);
    chk("ordering_error", ordering_error, 0);
    limits(200, 300, -100, -200);
    chk("err_code", ordering_error_code, `LCH_ERR_ORDERING);
    put(150);
    chk("old_limit_kept", over_out, 1);
    limits(200, 100, -100, -200);
  endtask
  // hysteresis walk up and down across all four limits
  task automatic t_hysteresis();
    int r [12] = '{101, 95, 90, 95, 201, 195, 150, -101, -95, -90,
      -201, -150};
    logic [3:0] e [12] = '{4, 4, 0, 0, 12, 12, 4, 2, 2, 0, 3, 2};
    hysteresis_setting = 20'h0_000A;
    for (int i = 0; i < 12; i++)
    begin
      put(r[i]);
      chk("decisions", {extreme_over_out, over_out, under_out,
        extreme_under_out}, e[i]);
    end
    hysteresis_setting = 20'h0_0000;
    put(101);
    put(100);
    chk("over_pass", {over_out, pass_out}, 1);
    chk("pass_led", pass_led, led_green);
    put(-100);
    chk("under_pass", {under_out, pass_out}, 1);
  endtask
  task automatic t_indicators_outer();
    int r [6] = '{150, 250, -150, -250, 250, -250};
    logic [1:0] e [6] = '{2, 3, 2, 3, 3, 3};
    for (int i = 0; i < 6; i++)
    begin
      outer_limit_enable = (i < 4);
      put(r[i]);
      chk("limit_led", r[i] > 0 ? upper_led : lower_led,
        e[i]);
    end
    outer_limit_enable = 1'b1;
  endtask
  task automatic t_area();
    int r [6] = '{150, 200, 250, -150, -200, -250};
    logic [3:0] e [6] = '{4, 0, 8, 2, 0, 1};
    output_pattern_select = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      put(r[i]);
      chk("area", {extreme_over_out, over_out, under_out,
        extreme_under_out}, e[i]);
    end
    output_pattern_select = 1'b0;
  endtask
  task automatic t_gating();
    logic [2:0] m [6] = '{0, 5, 4, 4, 2, 2};
    logic h [6] = '{0, 0, 0, 1, 0, 0};
    int nz [6] = '{10, 10, 10, 10, 200, 10};
    logic e [6] = '{1, 0, 0, 1, 0, 1};
    for (int i = 0; i < 6; i++)
    begin
      comparison_gating_mode = m[i];
      hold_req = h[i];
      near_zero_range = 20'(nz[i]);
      put(150);
      chk("gated_over", over_out, e[i]);
      chk("compare_active", compare_active, e[i]);
      chk("near_zero", near_zero, nz[i] >= 150);
    end
    comparison_gating_mode = 3'h1;
    step(40);
    chk("stable_over", {stable, over_out}, 3);
    comparison_gating_mode = 3'h3;
    near_zero_range = 20'h0_00C8;
    put(150);
    chk("nonzero_gate", over_out, 0);
    near_zero_range = 20'h0_000A;
    put(170);
    step(10);
    chk("moving_gate", {stable, over_out}, 0);
    comparison_gating_mode = 3'h0;
  endtask
  task automatic t_status_leds();
    for (int i = 0; i < 4; i++)
      for (int k = 0; k < 3; k++)
      begin
        hold_select = 4'(1 << i);
        hold_req = (k > 0);
        block_setting_enable = (k == 2);
        step(6);
        chk("hold_led", hold_led[i], k == 0 ? led_green :
          (k == 2 && i < 3) ? led_orange : led_red);
      end
    hold_req = 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      block_setting_enable = (k > 0);
      verdict_gate = (k == 2);
      step(2);
      chk("verdict_led", verdict_led, k == 1 ? 0 : led_green);
    end
    block_setting_enable = 1'b0;
    adjust_lock = 1'b1;
    step(2);
    chk("lock_leds", {adjust_lock_led, parameter_lock_led}, 8);
    adjust_lock = 1'b0;
    parameter_lock = 1'b1;
    step(2);
    chk("lock_leds", {adjust_lock_led, parameter_lock_led}, 2);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    {target, hold_req, edit_load, sign_key, edit_commit} = '0;
    {edit_slot, edit_magnitude, hysteresis_setting, hold_select} = '0;
    {output_pattern_select, block_setting_enable, verdict_gate} = '0;
    {adjust_lock, parameter_lock, comparison_gating_mode} = '0;
    outer_limit_enable = 1'b1;
    near_zero_range = 20'h0_000A;
    motion_bandwidth = 20'h0_0005;
    motion_detect_ticks = 16'h0002;
    step(10);
    rst_n = 1'b1;
    step(1);
    t_ordering();
    t_hysteresis();
    t_indicators_outer();
    t_area();
    t_gating();
    t_status_leds();
    close_out();
  end
  // the whole run needs well under 30 us
  initial
  begin
    #200us;
    n_mismatch++;
    close_out();
  end
endmodule

// >>> testbench/lch_front_end.sv
// measurement front end model: reading and hold state for the comparator
module lch_front_end #(
  parameter int LAG = 2
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // commands from the bench
  input wire logic signed [19:0] target,
  input wire logic hold_req,
  // toward the comparator
  output logic signed [19:0] reading,
  output logic hold_active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [20:0] pipe_q [LAG];
  // a slow front end: values settle LAG cycles late, held as levels
  always @(negedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pipe_q <= '{default: '0};
    else
    begin
      pipe_q[0] <= {hold_req, target};
      for (int i = 1; i < LAG; i++)
        pipe_q[i] <= pipe_q[i - 1];
    end
  end
  assign {hold_active, reading} = pipe_q[LAG - 1];
endmodule
